/* File: core/call_skip_clear_dec_exec.sv */
// decode and execute of call, bit skips, clear and decrement
`timescale 1ns/10ps
`include "call_skip_clear_defines.svh"

module call_skip_clear_dec_exec (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_instr_valid,
   input wire logic [`CSC_INSTR_W-1:0] i_instr,
   input wire logic [`CSC_PC_W-1:0] i_pc,
   input wire logic [`CSC_DATA_W-1:0] i_reg_rdata,
   output logic o_ready,
   output logic o_done,
   output logic o_discard,
   output call_skip_clear_pkg::pc_out_s o_pc,
   output call_skip_clear_pkg::stack_push_s o_stack,
   output call_skip_clear_pkg::reg_wr_s o_reg_wr,
   output call_skip_clear_pkg::acc_wr_s o_acc_wr,
   output call_skip_clear_pkg::zero_wr_s o_zero_wr
);

   ////////////////////////////////////////////////////////////////////////
   // decode

   function automatic call_skip_clear_pkg::op_e op_of(
      input logic [`CSC_INSTR_W-1:0] instr
   );
      logic [3:0] opc4;
      logic [5:0] opc6;
      opc4 = instr[`CSC_OPC4_MSB:`CSC_OPC4_LSB];
      opc6 = instr[`CSC_OPC6_MSB:`CSC_OPC6_LSB];
      if (opc4 == `CSC_OPC_CALL) begin
         op_of = call_skip_clear_pkg::OP_CALL;
      end else if (opc4 == `CSC_OPC_SKIP_LOW) begin
         op_of = call_skip_clear_pkg::OP_SKIP_LOW;
      end else if (opc4 == `CSC_OPC_SKIP_HIGH) begin
         op_of = call_skip_clear_pkg::OP_SKIP_HIGH;
      end else if (opc6 == `CSC_OPC_CLEAR) begin
         op_of = call_skip_clear_pkg::OP_CLEAR;
      end else if (opc6 == `CSC_OPC_DEC) begin
         op_of = call_skip_clear_pkg::OP_DEC;
      end else begin
         op_of = call_skip_clear_pkg::OP_NONE;
      end
   endfunction

   call_skip_clear_pkg::exec_state_s st_ff;
   call_skip_clear_pkg::exec_state_s nxt_st;
   call_skip_clear_pkg::op_e op;
   logic take;
   logic sel_bit;
   logic [`CSC_DATA_W-1:0] minus_one;
   logic minus_one_zero;
   logic [`CSC_REG_IDX_W-1:0] reg_idx;
   logic dest_reg;
   logic [`CSC_DATA_W-1:0] imm;

   assign op = op_of(i_instr);
   // the operand is only trusted while this block is ready for it
   assign take = i_instr_valid && st_ff.ready;
   assign reg_idx = i_instr[`CSC_REG_MSB:`CSC_REG_LSB];
   assign dest_reg = i_instr[`CSC_DEST_POS];
   assign imm = i_instr[`CSC_IMM_MSB:`CSC_IMM_LSB];

   operand_unit #(
      .DATA_W(`CSC_DATA_W),
      .BIT_IDX_W(`CSC_BIT_IDX_W)
   ) u_operand (
      .i_operand(i_reg_rdata),
      .i_bit_sel(i_instr[`CSC_BIT_MSB:`CSC_BIT_LSB]),
      .o_bit(sel_bit),
      .o_minus_one(minus_one),
      .o_minus_one_zero(minus_one_zero)
   );

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      nxt_st.discard = 1'b0;
      nxt_st.pc.load = 1'b0;
      nxt_st.stack.push = 1'b0;
      nxt_st.reg_wr.we = 1'b0;
      nxt_st.acc_wr.we = 1'b0;
      nxt_st.zero_wr.we = 1'b0;
      unique case (st_ff.phase)
         call_skip_clear_pkg::ST_EXEC: begin
            if (take && op != call_skip_clear_pkg::OP_NONE) begin
               nxt_st.done = 1'b1;
               nxt_st.pc.load = 1'b1;
               nxt_st.pc.value = i_pc + `CSC_PC_STEP;
               unique case (op)
                  call_skip_clear_pkg::OP_CALL: begin
                     nxt_st.stack.push = 1'b1;
                     nxt_st.stack.data = i_pc + `CSC_PC_STEP;
                     nxt_st.pc.value = {`CSC_CALL_PAGE, imm};
                     // the second cycle flushes the fetched word
                     nxt_st.phase = call_skip_clear_pkg::ST_DISCARD;
                     nxt_st.ready = 1'b0;
                     nxt_st.discard = 1'b1;
                  end
                  call_skip_clear_pkg::OP_SKIP_LOW: begin
                     if (!sel_bit) begin
                        nxt_st.pc.value = i_pc + `CSC_PC_SKIP_STEP;
                        nxt_st.phase = call_skip_clear_pkg::ST_DISCARD;
                        nxt_st.ready = 1'b0;
                        nxt_st.discard = 1'b1;
                     end
                  end
                  call_skip_clear_pkg::OP_SKIP_HIGH: begin
                     if (sel_bit) begin
                        nxt_st.pc.value = i_pc + `CSC_PC_SKIP_STEP;
                        nxt_st.phase = call_skip_clear_pkg::ST_DISCARD;
                        nxt_st.ready = 1'b0;
                        nxt_st.discard = 1'b1;
                     end
                  end
                  call_skip_clear_pkg::OP_CLEAR: begin
                     // register field is not checked for working target
                     if (dest_reg == `CSC_DEST_WORKING) begin
                        nxt_st.acc_wr.we = 1'b1;
                        nxt_st.acc_wr.data = `CSC_CLEAR_VALUE;
                     end else begin
                        nxt_st.reg_wr.we = 1'b1;
                        nxt_st.reg_wr.addr = reg_idx;
                        nxt_st.reg_wr.data = `CSC_CLEAR_VALUE;
                     end
                     nxt_st.zero_wr.we = 1'b1;
                     nxt_st.zero_wr.value = `CSC_ZERO_SET;
                  end
                  call_skip_clear_pkg::OP_DEC: begin
                     if (dest_reg == `CSC_DEST_WORKING) begin
                        nxt_st.acc_wr.we = 1'b1;
                        nxt_st.acc_wr.data = minus_one;
                     end else begin
                        nxt_st.reg_wr.we = 1'b1;
                        nxt_st.reg_wr.addr = reg_idx;
                        nxt_st.reg_wr.data = minus_one;
                     end
                     nxt_st.zero_wr.we = 1'b1;
                     nxt_st.zero_wr.value = minus_one_zero;
                  end
                  default: begin
                     nxt_st.done = 1'b0;
                     nxt_st.pc.load = 1'b0;
                  end
               endcase
            end
         end
         call_skip_clear_pkg::ST_DISCARD: begin
            // the word fetched during the taken cycle is dropped here
            nxt_st.phase = call_skip_clear_pkg::ST_EXEC;
            nxt_st.ready = 1'b1;
         end
         default: begin
            nxt_st.phase = call_skip_clear_pkg::ST_EXEC;
            nxt_st.ready = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_ff.phase <= call_skip_clear_pkg::ST_EXEC;
         st_ff.ready <= 1'b1;
         st_ff.discard <= 1'b0;
         st_ff.done <= 1'b0;
         st_ff.pc <= '{load: 1'b0, value: `CSC_PC_RESET};
         st_ff.stack <= '{push: 1'b0, data: `CSC_PC_RESET};
         st_ff.reg_wr <= '{we: 1'b0, addr: `CSC_REG_RESET,
                           data: `CSC_DATA_RESET};
         st_ff.acc_wr <= '{we: 1'b0, data: `CSC_DATA_RESET};
         st_ff.zero_wr <= '{we: 1'b0, value: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_ready = st_ff.ready;
   assign o_done = st_ff.done;
   assign o_discard = st_ff.discard;
   assign o_pc = st_ff.pc;
   assign o_stack = st_ff.stack;
   assign o_reg_wr = st_ff.reg_wr;
   assign o_acc_wr = st_ff.acc_wr;
   assign o_zero_wr = st_ff.zero_wr;

   ////////////////////////////////////////////////////////////////////////
   // checks

   logic call_t;
   logic low_t;
   logic high_t;
   logic clear_t;
   logic dec_t;
   assign call_t = take && op == call_skip_clear_pkg::OP_CALL;
   assign low_t = take && op == call_skip_clear_pkg::OP_SKIP_LOW;
   assign high_t = take && op == call_skip_clear_pkg::OP_SKIP_HIGH;
   assign clear_t = take && op == call_skip_clear_pkg::OP_CLEAR;
   assign dec_t = take && op == call_skip_clear_pkg::OP_DEC;

   call_push_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      call_t |=> o_stack.push && o_stack.data == $past(i_pc) + 9'h001)
      else $error("call did not push pc plus one");

   call_target_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      call_t |=> o_pc.load && o_pc.value == {1'b0, $past(imm)})
      else $error("call target wrong");

   call_two_cycles_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      call_t |=> !o_ready && !o_zero_wr.we && !o_reg_wr.we
         && !o_acc_wr.we ##1 o_ready && !o_done)
      else $error("call not two cycles or touched flags");

   skip_low_pc_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      low_t |=> o_pc.value == $past(i_pc)
         + ($past(sel_bit) ? 9'h001 : 9'h002))
      else $error("skip-if-low pc step wrong");

   skip_low_time_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      low_t |=> (o_ready == $past(sel_bit)) && !o_zero_wr.we)
      else $error("skip-if-low timing or flags wrong");

   skip_high_pc_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      high_t |=> o_pc.value == $past(i_pc)
         + ($past(sel_bit) ? 9'h002 : 9'h001))
      else $error("skip-if-high pc step wrong");

   skip_high_time_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      high_t |=> (o_ready != $past(sel_bit)) && !o_zero_wr.we)
      else $error("skip-if-high timing or flags wrong");

   clear_zero_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      clear_t |=> o_zero_wr.we && o_zero_wr.value && o_ready
         && o_pc.value == $past(i_pc) + 9'h001
         && (o_acc_wr.we ? o_acc_wr.data : o_reg_wr.data) == 8'h00)
      else $error("clear result wrong");

   dec_result_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      dec_t |=> o_zero_wr.we && o_ready
         && (o_acc_wr.we ? o_acc_wr.data : o_reg_wr.data)
            == $past(i_reg_rdata) - 8'h01
         && o_zero_wr.value == ($past(i_reg_rdata) == 8'h01))
      else $error("decrement result wrong");

   dest_route_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (clear_t || dec_t) |=> (o_reg_wr.we == $past(dest_reg))
         && (o_acc_wr.we != $past(dest_reg))
         && (!o_reg_wr.we || o_reg_wr.addr == $past(reg_idx)))
      else $error("destination routing wrong");

   discard_next_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      o_discard |-> !o_ready && $past(take) ##1 o_ready && !o_discard)
      else $error("discard slot wrong");

   refused_word_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      !o_ready |=> !o_done && !o_pc.load && !o_zero_wr.we)
      else $error("word taken in discard slot");

   skip_quiet_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (low_t || high_t) |=> !o_acc_wr.we && !o_reg_wr.we
         && !o_stack.push && !o_zero_wr.we)
      else $error("skip wrote a result");

   clear_single_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      clear_t |=> o_done && o_pc.load && !o_discard
         && !o_stack.push)
      else $error("clear not single cycle");

   dec_pc_step_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      dec_t |=> o_done && o_pc.load && !o_discard
         && o_pc.value == $past(i_pc) + `CSC_PC_STEP)
      else $error("decrement pc step wrong");

endmodule

/* File: core/call_skip_clear_defines.svh */
// constants for the call, skip, clear and decrement decode block
`ifndef CALL_SKIP_CLEAR_DEFINES_SVH
`define CALL_SKIP_CLEAR_DEFINES_SVH

`define CSC_INSTR_W 12
`define CSC_PC_W 9
`define CSC_DATA_W 8
`define CSC_REG_IDX_W 5
`define CSC_BIT_IDX_W 3

`define CSC_OPC4_MSB 11
`define CSC_OPC4_LSB 8
`define CSC_OPC6_MSB 11
`define CSC_OPC6_LSB 6
`define CSC_IMM_MSB 7
`define CSC_IMM_LSB 0
`define CSC_BIT_MSB 7
`define CSC_BIT_LSB 5
`define CSC_DEST_POS 5
`define CSC_REG_MSB 4
`define CSC_REG_LSB 0

`define CSC_OPC_CALL 4'h9
`define CSC_OPC_SKIP_LOW 4'h6
`define CSC_OPC_SKIP_HIGH 4'h7
`define CSC_OPC_CLEAR 6'h01
`define CSC_OPC_DEC 6'h03

`define CSC_DEST_WORKING 1'h0
`define CSC_CALL_PAGE 1'h0
`define CSC_CLEAR_VALUE 8'h00
`define CSC_ZERO_SET 1'h1
`define CSC_PC_STEP 9'h001
`define CSC_PC_SKIP_STEP 9'h002
`define CSC_PC_RESET 9'h000
`define CSC_DATA_RESET 8'h00
`define CSC_REG_RESET 5'h00

`endif

/* File: core/call_skip_clear_pkg.sv */
// types shared by the call, skip, clear and decrement decode block
package call_skip_clear_pkg;

   typedef enum logic [1:0] {
      ST_EXEC = 2'b01,
      ST_DISCARD = 2'b10
   } phase_e;

   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_CALL = 3'h1,
      OP_SKIP_LOW = 3'h2,
      OP_SKIP_HIGH = 3'h3,
      OP_CLEAR = 3'h4,
      OP_DEC = 3'h5
   } op_e;

   typedef struct packed {
      logic load;
      logic [8:0] value;
   } pc_out_s;

   typedef struct packed {
      logic push;
      logic [8:0] data;
   } stack_push_s;

   typedef struct packed {
      logic we;
      logic [4:0] addr;
      logic [7:0] data;
   } reg_wr_s;

   typedef struct packed {
      logic we;
      logic [7:0] data;
   } acc_wr_s;

   typedef struct packed {
      logic we;
      logic value;
   } zero_wr_s;

   typedef struct packed {
      phase_e phase;
      logic ready;
      logic discard;
      logic done;
      pc_out_s pc;
      stack_push_s stack;
      reg_wr_s reg_wr;
      acc_wr_s acc_wr;
      zero_wr_s zero_wr;
   } exec_state_s;

endpackage

/* File: core/operand_unit.sv */
// bit select and minus-one arithmetic on the register operand
`timescale 1ns/10ps
`include "call_skip_clear_defines.svh"

module operand_unit #(
   parameter int DATA_W = `CSC_DATA_W,
   parameter int BIT_IDX_W = `CSC_BIT_IDX_W
) (
   input wire logic [DATA_W-1:0] i_operand,
   input wire logic [BIT_IDX_W-1:0] i_bit_sel,
   output logic o_bit,
   output logic [DATA_W-1:0] o_minus_one,
   output logic o_minus_one_zero
);

   // refuse widths that the bit select cannot cover exactly
   if (DATA_W != (1 << BIT_IDX_W)) begin : g_width_bad
      $error("operand width must equal two to the bit index width");
   end

   logic [DATA_W-1:0] one_w;
   assign one_w = {{(DATA_W-1){1'b0}}, 1'b1};

   // wraps 0x00 to 0xFF, as two's complement does
   assign o_minus_one = i_operand - one_w;
   assign o_minus_one_zero = (o_minus_one == '0);
   assign o_bit = i_operand[i_bit_sel];

endmodule

/* File: test/call_skip_clear_dec_exec_tb.sv */
// self-checking bench for the call, skip, clear and decrement block
`timescale 1ns/10ps
module call_skip_clear_dec_exec_tb;
   logic i_clk;
   logic i_rst_n;
   logic i_instr_valid;
   logic [11:0] i_instr;
   logic [8:0] i_pc;
   logic [7:0] i_reg_rdata;
   logic o_ready;
   logic o_done;
   logic o_discard;
   call_skip_clear_pkg::pc_out_s o_pc;
   call_skip_clear_pkg::stack_push_s o_stack;
   call_skip_clear_pkg::reg_wr_s o_reg_wr;
   call_skip_clear_pkg::acc_wr_s o_acc_wr;
   call_skip_clear_pkg::zero_wr_s o_zero_wr;
   int errors;
   int n_compared;
   logic tail_v;
   logic [11:0] tail_i;

   call_skip_clear_dec_exec uut (.i_clk, .i_rst_n, .i_instr_valid,
      .i_instr, .i_pc, .i_reg_rdata, .o_ready, .o_done, .o_discard,
      .o_pc, .o_stack, .o_reg_wr, .o_acc_wr, .o_zero_wr);
   regfile_model rf (.i_clk(i_clk), .i_addr(i_instr[4:0]),
      .i_wr(o_reg_wr), .o_rdata(i_reg_rdata));

   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // present one word; return 1 ns after the edge that took it
   task automatic exec(input logic [11:0] w, input logic [8:0] pc);
      @(posedge i_clk);
      i_instr_valid <= 1'b1;
      i_instr <= w;
      i_pc <= pc;
      @(posedge i_clk);
      i_instr_valid <= tail_v;
      i_instr <= tail_i;
      #1;
   endtask

   task automatic ck_flow(input logic [8:0] nxt, input logic skip);
      chk("done", 1, o_done);
      chk("pc load", 1, o_pc.load);
      chk("pc value", nxt, o_pc.value);
      chk("ready", !skip, o_ready);
      chk("discard", skip, o_discard);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // a valid word is held through the dead cycle: it must be dropped
   task automatic t_call(input logic [7:0] v, input logic [8:0] pc);
      logic [8:0] ret;
      ret = pc + 9'h001;
      tail_v = 1'b1;
      tail_i = 12'h043;
      exec({4'h9, v}, pc);
      ck_flow({1'b0, v}, 1'b1);
      chk("push", 1, o_stack.push);
      chk("push data", ret, o_stack.data);
      chk("call zero we", 0, o_zero_wr.we);
      tail_v = 1'b0;
      @(posedge i_clk);
      i_instr_valid <= 1'b0;
      #1;
      chk("dropped done", 0, o_done);
      chk("dropped acc we", 0, o_acc_wr.we);
      chk("ready back", 1, o_ready);
   endtask

   // register 5 holds 0x05: bit 0 set, bit 1 clear
   task automatic t_skip(input logic [3:0] op, input logic [2:0] b);
      logic [7:0] val;
      logic taken;
      val = 8'h05;
      taken = val[b] ^ (op == 4'h6);
      exec({op, b, 5'h05}, 9'h1FE);
      ck_flow(taken ? 9'h000 : 9'h1FF, taken);
      chk("skip zero we", 0, o_zero_wr.we);
      chk("skip push", 0, o_stack.push);
      if (taken) begin
         @(posedge i_clk);
         #1;
         chk("skip ready back", 1, o_ready);
      end
   endtask

   task automatic t_wr(input logic [11:0] w, input logic [7:0] res,
                       input logic z);
      exec(w, 9'h0A0);
      ck_flow(9'h0A1, 1'b0);
      chk("reg we", w[5], o_reg_wr.we);
      chk("acc we", !w[5], o_acc_wr.we);
      chk("result", res, w[5] ? o_reg_wr.data : o_acc_wr.data);
      if (w[5])
         chk("reg addr", w[4:0], o_reg_wr.addr);
      chk("zero we", 1, o_zero_wr.we);
      chk("zero value", z, o_zero_wr.value);
   endtask

   // reset dropped right after a call is taken: nothing may stand after it
   task automatic t_reset();
      @(posedge i_clk);
      i_instr_valid <= 1'b1;
      i_instr <= 12'h9AB;
      i_pc <= 9'h020;
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      i_instr_valid <= 1'b0;
      #1;
      chk("reset mid done", 0, o_done);
      chk("reset mid discard", 0, o_discard);
      chk("reset mid push", 0, o_stack.push);
      chk("reset mid load", 0, o_pc.load);
      chk("reset mid ready", 1, o_ready);
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
   endtask

   // words of other opcodes pass silently
   task automatic t_other();
      exec(12'h800, 9'h040);
      chk("other done", 0, o_done);
      chk("other load", 0, o_pc.load);
      chk("other ready", 1, o_ready);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   // whole run needs under fifty cycles; allow ample margin
   initial begin
      repeat (2000) @(posedge i_clk);
      errors++;
      give_verdict();
   end

   initial begin
      errors = 0;
      n_compared = 0;
      i_rst_n = 1'b0;
      i_instr_valid = 1'b0;
      i_instr = 12'h000;
      i_pc = 9'h000;
      tail_v = 1'b0;
      tail_i = 12'h000;
      repeat (12) @(posedge i_clk);
      chk("reset ready", 1, o_ready);
      chk("reset done", 0, o_done);
      i_rst_n <= 1'b1;
      t_call(8'hAB, 9'h010);
      t_call(8'hFF, 9'h1FF);
      for (int op = 6; op < 8; op++) begin
         for (int b = 0; b < 2; b++) begin
            t_skip(4'(op), 3'(b));
         end
      end
      t_reset();
      t_wr(12'h063, 8'h00, 1'b1);
      t_wr(12'h040, 8'h00, 1'b1);
      t_wr(12'h0C1, 8'h00, 1'b1);
      t_wr(12'h0E0, 8'hFF, 1'b0);
      t_wr(12'h0E7, 8'h06, 1'b0);
      t_other();
      give_verdict();
   end
endmodule

/* File: test/regfile_model.sv */
// register file model feeding the block's operand read port
`timescale 1ns/10ps
module regfile_model (
   input wire logic i_clk,
   input wire logic [4:0] i_addr,
   input wire call_skip_clear_pkg::reg_wr_s i_wr,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [32];
   // each register starts out holding its own index
   initial begin
      for (int i = 0; i < 32; i++) begin
         mem[i] = 8'(i);
      end
   end
   // read is combinational, valid in the same cycle as the word
   assign o_rdata = mem[i_addr];
   always @(posedge i_clk) begin
      if (i_wr.we === 1'b1) begin
         mem[i_wr.addr] <= i_wr.data;
      end
   end
endmodule
